// >>> src/acc_top.sv
`timescale 1ns/1ps
module acc_top #(
	parameter int ADDR_W = 8
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic cmp_raw_in,
	input wire logic pos_pin_dig_in,
	input wire logic neg_pin_dig_in,
	input wire logic irq_vector_taken_in,
	output logic cmp_irq_out,
	output logic irq_out,
	output logic cmp_power_off_out,
	output logic cmp_ref_select_out,
	output acc_pkg::acc_neg_type neg_src_out,
	output logic pos_pin_buf_off_out,
	output logic neg_pin_buf_off_out,
	output logic [3:0] conv_pin_buf_off_out,
	output logic pos_pin_read_out,
	output logic neg_pin_read_out,
	output logic [2:0] trig_sel_out
);
	import acc_pkg::*;

	// ****************************************
	// Elaboration check
	// ****************************************
	if (ADDR_W < 8) begin : g_bad_addr
		$error("acc_top: ADDR_W must be at least 8");
	end
	// Field widths must match the register layout
	if (TRIG_W != CONVB_TRIG_HI + 1) begin : g_bad_trig
		$error("acc_top: TRIG_W does not match the trigger field");
	end
	if (DIDR_W != DIDR_TOP + 1) begin : g_bad_didr
		$error("acc_top: DIDR_W does not match the disable field");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic cmp_s1;
		logic cmp_s2;
		logic cmp_prev;
		logic pos_s1;
		logic pos_s2;
		logic neg_s1;
		logic neg_s2;
		logic flag;
		logic ie;
		logic power_off;
		logic ref_sel;
		acc_mode_type mode;
		logic mux_en;
		logic [TRIG_W-1:0] trig;
		logic [DIDR_W-1:0] didr;
		logic conv_en;
		logic [1:0] chan;
		logic gie;
		logic irq_stat;
		logic irq_en;
		logic waitreq;
		logic [31:0] rdata;
		logic cmp_irq;
		logic irq;
		acc_neg_type neg_src;
		logic pos_read;
		logic neg_read;
	} acc_state_type;

	acc_state_type s_q;
	acc_state_type s_d;
	logic event_w;
	logic [5:0] idx_w;
	logic mapped_w;
	logic wr_w;
	logic [7:0] wb_w;
	logic [7:0] csr_rd_w;

	// Word index and access decode
	assign idx_w = avs_address_in[7:2];
	assign mapped_w = (avs_address_in[1:0] == 2'h0);
	assign wr_w = avs_write_in && !s_q.waitreq && mapped_w && avs_byteenable_in[0];
	assign wb_w = avs_writedata_in[7:0];

	// Edge event of synchronized output, selected by mode
	always_comb begin
		case (s_q.mode)
			ACC_MODE_TOGGLE: event_w = s_q.cmp_s2 ^ s_q.cmp_prev;
			ACC_MODE_FALL: event_w = s_q.cmp_prev && !s_q.cmp_s2;
			ACC_MODE_RISE: event_w = !s_q.cmp_prev && s_q.cmp_s2;
			default: event_w = 1'b0;
		endcase
	end

	// Control/status byte as read; bit 2 always zero
	always_comb begin
		csr_rd_w = RST_BYTE;
		csr_rd_w[CSR_POWER_OFF] = s_q.power_off;
		csr_rd_w[CSR_REF_SEL] = s_q.ref_sel;
		csr_rd_w[CSR_OUT] = s_q.cmp_s2;
		csr_rd_w[CSR_FLAG] = s_q.flag;
		csr_rd_w[CSR_IRQ_EN] = s_q.ie;
		csr_rd_w[CSR_MODE_HI:CSR_MODE_LO] = s_q.mode;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		// Two-stage synchronizers
		s_d.cmp_s1 = cmp_raw_in;
		s_d.cmp_s2 = s_q.cmp_s1;
		s_d.cmp_prev = s_q.cmp_s2;
		s_d.pos_s1 = pos_pin_dig_in;
		s_d.pos_s2 = s_q.pos_s1;
		s_d.neg_s1 = neg_pin_dig_in;
		s_d.neg_s2 = s_q.neg_s1;
		// Bus handshake: one wait cycle per request
		s_d.waitreq = !((avs_read_in || avs_write_in) && s_q.waitreq);
		// Read data of the addressed word, shown in the next cycle
		s_d.rdata = RST_WORD;
		if (mapped_w) begin
			case (idx_w)
				IDX_CONV_B: begin
					s_d.rdata[CONVB_MUX_EN] = s_q.mux_en;
					s_d.rdata[CONVB_TRIG_HI:0] = s_q.trig;
				end
				IDX_CSR: s_d.rdata[7:0] = csr_rd_w;
				IDX_DIDR: s_d.rdata[DIDR_TOP:0] = s_q.didr;
				IDX_CONV_CTRL: begin
					s_d.rdata[CTRL_CONV_EN] = s_q.conv_en;
					s_d.rdata[CTRL_CHAN_HI:CTRL_CHAN_LO] = s_q.chan;
					s_d.rdata[CTRL_GIE] = s_q.gie;
				end
				IDX_IRQ_STAT: s_d.rdata[IRQ_CMP_BIT] = s_q.irq_stat;
				IDX_IRQ_EN: s_d.rdata[IRQ_CMP_BIT] = s_q.irq_en;
				default: s_d.rdata = RST_WORD;
			endcase
		end
		// Register writes, taken in the cycle waitrequest is low
		if (wr_w) begin
			case (idx_w)
				IDX_CONV_B: begin
					s_d.mux_en = wb_w[CONVB_MUX_EN];
					s_d.trig = wb_w[CONVB_TRIG_HI:0];
				end
				IDX_CSR: begin
					s_d.power_off = wb_w[CSR_POWER_OFF];
					s_d.ref_sel = wb_w[CSR_REF_SEL];
					s_d.ie = wb_w[CSR_IRQ_EN];
					s_d.mode = acc_mode_type'(wb_w[CSR_MODE_HI:CSR_MODE_LO]);
				end
				IDX_DIDR: s_d.didr = wb_w[DIDR_TOP:0];
				IDX_CONV_CTRL: begin
					s_d.conv_en = wb_w[CTRL_CONV_EN];
					s_d.chan = wb_w[CTRL_CHAN_HI:CTRL_CHAN_LO];
					s_d.gie = wb_w[CTRL_GIE];
				end
				IDX_IRQ_EN: s_d.irq_en = wb_w[IRQ_CMP_BIT];
				default: s_d.gie = s_q.gie;
			endcase
		end
		// Flag: vector or write-one clears, a new event wins
		if (irq_vector_taken_in) begin
			s_d.flag = 1'b0;
		end
		if (wr_w && idx_w == IDX_CSR && wb_w[CSR_FLAG]) begin
			s_d.flag = 1'b0;
		end
		if (event_w) begin
			s_d.flag = 1'b1;
		end
		// Sticky status with write-one clear, set wins
		if (wr_w && idx_w == IDX_IRQ_CLR && wb_w[IRQ_CMP_BIT]) begin
			s_d.irq_stat = 1'b0;
		end
		if (event_w) begin
			s_d.irq_stat = 1'b1;
		end
		// Registered outputs from next state
		s_d.cmp_irq = s_d.flag && s_d.ie && s_d.gie;
		s_d.irq = s_d.irq_stat && s_d.irq_en;
		// Negative input source
		if (s_d.mux_en && !s_d.conv_en) begin
			s_d.neg_src = acc_neg_type'({1'b0, s_d.chan} + 3'h1);
		end else begin
			s_d.neg_src = ACC_NEG_PIN;
		end
		// Pin reads masked by the buffer-off bits
		s_d.pos_read = s_q.pos_s2 && !s_d.didr[DIDR_POS];
		s_d.neg_read = s_q.neg_s2 && !s_d.didr[DIDR_NEG];
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '0;
			s_q.waitreq <= 1'b1;
			s_q.mode <= ACC_MODE_TOGGLE;
			s_q.neg_src <= ACC_NEG_PIN;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from state
	assign avs_readdata_out = s_q.rdata;
	assign avs_waitrequest_out = s_q.waitreq;
	assign cmp_irq_out = s_q.cmp_irq;
	assign irq_out = s_q.irq;
	assign cmp_power_off_out = s_q.power_off;
	assign cmp_ref_select_out = s_q.ref_sel;
	assign neg_src_out = s_q.neg_src;
	assign pos_pin_buf_off_out = s_q.didr[DIDR_POS];
	assign neg_pin_buf_off_out = s_q.didr[DIDR_NEG];
	assign conv_pin_buf_off_out = s_q.didr[DIDR_TOP:DIDR_NEG+1];
	assign pos_pin_read_out = s_q.pos_read;
	assign neg_pin_read_out = s_q.neg_read;
	assign trig_sel_out = s_q.trig;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	// Synchronizer follows the raw result
	sync_delay_a: assert property (s_q.cmp_s1 ##1 s_q.cmp_s1 |-> csr_rd_w[CSR_OUT])
		else $error("synchronized output not following raw");

	sync_fall_a: assert property (!s_q.cmp_s1 ##1 !s_q.cmp_s1 |-> !csr_rd_w[CSR_OUT])
		else $error("synchronized output not following raw low");

	// Selected events set the flag
	rise_flag_a: assert property ((s_q.mode == ACC_MODE_RISE) && !s_q.cmp_prev
		&& s_q.cmp_s2 |=> s_q.flag)
		else $error("rising edge did not set flag");

	fall_flag_a: assert property ((s_q.mode == ACC_MODE_FALL) && s_q.cmp_prev
		&& !s_q.cmp_s2 |=> s_q.flag)
		else $error("falling edge did not set flag");

	toggle_flag_a: assert property ((s_q.mode == ACC_MODE_TOGGLE)
		&& (s_q.cmp_prev != s_q.cmp_s2) |=> s_q.flag)
		else $error("toggle did not set flag");

	rsvd_mode_a: assert property ((s_q.mode == ACC_MODE_RSVD) && !s_q.flag
		&& !irq_vector_taken_in |=> !s_q.flag)
		else $error("reserved mode set flag");

	set_wins_a: assert property (event_w |=> s_q.flag)
		else $error("event lost against a clear");

	flag_hold_a: assert property (s_q.flag && !irq_vector_taken_in
		&& !(wr_w && (idx_w == IDX_CSR) && wb_w[CSR_FLAG]) |=> s_q.flag)
		else $error("flag cleared without a clear");

	// Flag clearing
	vector_clear_a: assert property (irq_vector_taken_in && !event_w |=> !s_q.flag)
		else $error("vector did not clear flag");

	w1c_clear_a: assert property (wr_w && (idx_w == IDX_CSR) && wb_w[CSR_FLAG]
		&& !event_w |=> !s_q.flag)
		else $error("write one did not clear flag");

	// Interrupt requests and sticky status
	irq_gate_a: assert property (cmp_irq_out == (s_q.flag && s_q.ie && s_q.gie))
		else $error("interrupt request mismatch");

	irq_out_gate_a: assert property (irq_out == (s_q.irq_stat && s_q.irq_en))
		else $error("status interrupt mismatch");

	stat_sticky_a: assert property (event_w |=> s_q.irq_stat)
		else $error("event did not set status");

	// Power and reference follow the written control byte
	power_off_a: assert property (wr_w && (idx_w == IDX_CSR)
		|=> cmp_power_off_out == $past(wb_w[CSR_POWER_OFF]))
		else $error("power off does not follow write");

	ref_sel_a: assert property (wr_w && (idx_w == IDX_CSR)
		|=> cmp_ref_select_out == $past(wb_w[CSR_REF_SEL]))
		else $error("reference select does not follow write");

	// Negative input routing
	neg_route_a: assert property (s_q.mux_en && !s_q.conv_en
		|-> neg_src_out == acc_neg_type'({1'b0, s_q.chan} + 3'h1))
		else $error("negative input route wrong");

	neg_pin_a: assert property (!s_q.mux_en || s_q.conv_en
		|-> neg_src_out == ACC_NEG_PIN)
		else $error("dedicated negative pin not selected");

	conv_on_a: assert property (s_q.conv_en |-> neg_src_out == ACC_NEG_PIN)
		else $error("converter on but pin replaced");

	// Register map and pin buffers
	rsvd_bit_a: assert property (csr_rd_w[2] == 1'b0)
		else $error("unused bit reads nonzero");

	buf_off_a: assert property (s_q.didr[DIDR_POS] |-> !pos_pin_read_out)
		else $error("disabled pin reads nonzero");

	neg_buf_off_a: assert property (s_q.didr[DIDR_NEG] |-> !neg_pin_read_out)
		else $error("disabled negative pin reads nonzero");

	pos_pin_a: assert property (!s_q.didr[DIDR_POS]
		|-> pos_pin_read_out == $past(s_q.pos_s2))
		else $error("enabled pin read wrong");

	neg_read_a: assert property (!s_q.didr[DIDR_NEG]
		|-> neg_pin_read_out == $past(s_q.neg_s2))
		else $error("enabled negative pin read wrong");

	trig_sel_a: assert property (wr_w && (idx_w == IDX_CONV_B)
		|=> trig_sel_out == $past(wb_w[CONVB_TRIG_HI:0]))
		else $error("trigger select does not follow write");

	unmapped_zero_a: assert property (!mapped_w |=> avs_readdata_out == RST_WORD)
		else $error("misaligned address read nonzero");

	lane_off_a: assert property (avs_write_in && !avs_byteenable_in[0]
		|=> $stable(s_q.didr) && $stable(s_q.chan))
		else $error("write without lane zero took effect");

	// Bus handshake
	wait_one_a: assert property ((avs_read_in || avs_write_in) && s_q.waitreq
		|=> !avs_waitrequest_out)
		else $error("waitrequest not released after one cycle");

	wait_single_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");

	wait_idle_a: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out
		|=> avs_waitrequest_out)
		else $error("waitrequest dropped while idle");

endmodule

// >>> src/acc_pkg.sv
// Behaviour
// - Comparator result synchronized, readable after 1-2 cycles
// - Mode field: toggle, reserved, falling, rising
// - Flag sets on selected event, enable irrelevant
// - Flag clears on vector taken or write-one
// - Interrupt requested when flag, enable, global enable
// - Disable bit powers comparator off
// - Reference select drives positive input from reference
// - Mux enable, converter off: channel picks pin
// - Otherwise dedicated negative pin feeds negative input
// - Unused control bit reads zero, ignores writes
// - Buffer-off bits disable buffer, port reads zero
// - Converter enable high while converter switched on
package acc_pkg;

	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [5:0] IDX_CONV_B = 6'h03;
	localparam logic [5:0] IDX_CSR = 6'h08;
	localparam logic [5:0] IDX_DIDR = 6'h14;
	localparam logic [5:0] IDX_CONV_CTRL = 6'h20;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h21;
	localparam logic [5:0] IDX_IRQ_CLR = 6'h22;
	localparam logic [5:0] IDX_IRQ_EN = 6'h23;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CSR_POWER_OFF = 7;
	localparam int CSR_REF_SEL = 6;
	localparam int CSR_OUT = 5;
	localparam int CSR_FLAG = 4;
	localparam int CSR_IRQ_EN = 3;
	localparam int CSR_MODE_HI = 1;
	localparam int CSR_MODE_LO = 0;
	localparam int CONVB_MUX_EN = 6;
	localparam int CONVB_TRIG_HI = 2;
	localparam int CTRL_CONV_EN = 0;
	localparam int CTRL_CHAN_LO = 1;
	localparam int CTRL_CHAN_HI = 2;
	localparam int CTRL_GIE = 3;
	localparam int DIDR_POS = 0;
	localparam int DIDR_NEG = 1;
	localparam int DIDR_TOP = 5;
	localparam int IRQ_CMP_BIT = 0;

	// ****************************************
	// Reset values and widths
	// ****************************************
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam int TRIG_W = 3;
	localparam int DIDR_W = 6;

	// Interrupt mode encodings
	typedef enum logic [1:0] {
		ACC_MODE_TOGGLE = 2'h0,
		ACC_MODE_RSVD = 2'h1,
		ACC_MODE_FALL = 2'h2,
		ACC_MODE_RISE = 2'h3
	} acc_mode_type;

	// Negative input source encodings
	typedef enum logic [2:0] {
		ACC_NEG_PIN = 3'h0,
		ACC_NEG_CONV0 = 3'h1,
		ACC_NEG_CONV1 = 3'h2,
		ACC_NEG_CONV2 = 3'h3,
		ACC_NEG_CONV3 = 3'h4
	} acc_neg_type;

endpackage

// >>> dv/acc_cmp_model.sv
`timescale 1ns/1ps
// ****************************************
// Analog comparator stand-in
// ****************************************
module acc_cmp_model (
	input wire logic ref_sel_in,
	input wire acc_pkg::acc_neg_type neg_src_in,
	input wire logic [55:0] volt_in,
	output logic raw_out
);
	import acc_pkg::*;
	logic [7:0] p;
	logic [7:0] n;
	// Levels: pos pin, reference, neg pin, converter pins 0..3
	always_comb begin
		p = ref_sel_in ? volt_in[15:8] : volt_in[7:0];
		n = volt_in[8*(int'(neg_src_in)+2) +: 8];
		raw_out = p > n;
	end
endmodule

// >>> dv/test_analog_comparator_control.sv
`timescale 1ns/1ps
// ****************************************
// Self-checking bench
// ****************************************
module test_analog_comparator_control;
	import acc_pkg::*;
	logic clk, rst, re, we, vec, pd, nd, raw, wait_o, cirq, irq;
	logic poff, rsel, pbo, nbo, pr, nr;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, got;
	logic [3:0] cbo, be;
	logic [2:0] trg;
	logic [55:0] v;
	acc_neg_type nsrc;
	int err_total, tests_run;

	acc_top i_acc_top (.core_clk_in(clk), .rst_in(rst), .avs_address_in(adr),
		.avs_read_in(re), .avs_write_in(we), .avs_writedata_in(wdat),
		.avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wait_o),
		.cmp_raw_in(raw), .pos_pin_dig_in(pd), .neg_pin_dig_in(nd),
		.irq_vector_taken_in(vec), .cmp_irq_out(cirq), .irq_out(irq),
		.cmp_power_off_out(poff), .cmp_ref_select_out(rsel), .neg_src_out(nsrc),
		.pos_pin_buf_off_out(pbo), .neg_pin_buf_off_out(nbo),
		.conv_pin_buf_off_out(cbo), .pos_pin_read_out(pr), .neg_pin_read_out(nr),
		.trig_sel_out(trg));
	acc_cmp_model i_acc_cmp_model (.ref_sel_in(rsel), .neg_src_in(nsrc), .volt_in(v),
		.raw_out(raw));

	task give_verdict;
		if (err_total == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("wrong value %s exp %h got %h", s, e, g);
			err_total++;
		end
	endtask

	task cy(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One Avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
		@(posedge clk);
		adr <= {i, 2'h0};
		wdat <= {24'h0, d};
		we <= w;
		re <= !w;
		do begin
			@(posedge clk);
		end while (wait_o !== 1'b0);
		got = rdat;
		we <= 1'b0;
		re <= 1'b0;
		chk("waitreq", 0, wait_o);
	endtask

	task automatic t_mode;
		for (int i = 0; i < 4; i++) begin
			bus(1, IDX_CSR, 8'(i));
			bus(1, IDX_CSR, 8'(i) | 8'h10);
			v[7:0] <= 8'hC0;
			cy(6);
			bus(0, IDX_CSR, 0);
			chk("rise", (i == 0 || i == 3) ? 32'h30 : 32'h20, got & 32'h30);
			bus(1, IDX_CSR, 8'(i) | 8'h10);
			v[7:0] <= 8'h40;
			cy(6);
			bus(0, IDX_CSR, 0);
			chk("fall", (i == 0 || i == 2) ? 32'h10 : 32'h0, got & 32'h30);
		end
	endtask

	task automatic t_irq;
		bus(1, IDX_CSR, 8'h10);
		bus(1, IDX_CSR, 8'h08);
		bus(1, IDX_CONV_CTRL, 8'h08);
		bus(1, IDX_IRQ_EN, 8'h01);
		bus(1, IDX_IRQ_CLR, 8'h01);
		v[7:0] <= 8'hC0;
		cy(6);
		chk("cmp irq", 1, cirq);
		chk("irq", 1, irq);
		bus(1, IDX_IRQ_EN, 0);
		cy(2);
		chk("irq mask", 0, irq);
		@(posedge clk);
		vec <= 1'b1;
		@(posedge clk);
		vec <= 1'b0;
		cy(3);
		chk("vec clr", 0, cirq);
		bus(0, IDX_IRQ_STAT, 0);
		chk("stat", 1, got);
		bus(1, IDX_IRQ_CLR, 8'h01);
		bus(0, IDX_IRQ_STAT, 0);
		chk("stat clr", 0, got);
		bus(1, IDX_CONV_CTRL, 0);
		v[7:0] <= 8'h40;
		cy(6);
		chk("no gie", 0, cirq);
		bus(0, IDX_CSR, 0);
		chk("flag", 32'h18, got & 32'h18);
		bus(1, IDX_CSR, 8'h10);
		bus(0, IDX_CSR, 0);
		chk("w1c", 0, got & 32'h18);
	endtask

	task automatic t_mux;
		bus(1, IDX_CONV_B, 8'hFF);
		bus(0, IDX_CONV_B, 0);
		chk("conv b", 32'h47, got);
		chk("trig", 7, trg);
		for (int c = 0; c < 4; c++) begin
			bus(1, IDX_CONV_CTRL, 8'(c * 2));
			cy(2);
			chk("neg src", c + 1, nsrc);
		end
		bus(1, IDX_CONV_CTRL, 8'h07);
		cy(2);
		chk("conv on", 0, nsrc);
		bus(1, IDX_CONV_B, 0);
		bus(1, IDX_CONV_CTRL, 8'h06);
		cy(2);
		chk("mux off", 0, nsrc);
		v[15:8] <= 8'hFF;
		bus(1, IDX_CSR, 8'hC4);
		cy(4);
		chk("ref", 1, rsel);
		chk("power", 1, poff);
		bus(0, IDX_CSR, 0);
		chk("csr", 32'hF0, got);
		bus(1, IDX_CSR, 0);
		cy(2);
		chk("power on", 0, poff);
	endtask

	task automatic t_pins;
		bus(1, IDX_DIDR, 8'h01);
		cy(4);
		chk("pos rd", 0, pr);
		chk("neg rd", 1, nr);
		bus(1, IDX_DIDR, 8'hFE);
		bus(0, IDX_DIDR, 0);
		chk("didr", 32'h3E, got);
		chk("bufs", 32'h3E, {cbo, nbo, pbo});
		chk("pins", 32'h1, {nr, pr});
		bus(0, 6'h3F, 0);
		chk("unmapped", 0, got);
		be <= 4'hE;
		bus(1, IDX_DIDR, 8'h01);
		be <= 4'hF;
		bus(0, IDX_DIDR, 0);
		chk("lane off", 32'h3E, got);
	endtask

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard
	initial begin
		#100000;
		err_total++;
		give_verdict;
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		{re, we, vec} = 3'h0;
		{pd, nd} = 2'h3;
		adr = 8'h00;
		wdat = 32'h0;
		be = 4'hF;
		v = 56'h8080_8080_8080_40;
		err_total = 0;
		tests_run = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		bus(0, IDX_CSR, 0);
		chk("csr rst", 0, got & 32'hDF);
		bus(0, IDX_DIDR, 0);
		chk("didr rst", 0, got);
		t_mode;
		t_irq;
		t_mux;
		t_pins;
		give_verdict;
	end
endmodule
